// File: rtl/pirq_consts.svh
// constants for the peripheral interrupt router
`ifndef PIRQ_CONSTS_SVH
`define PIRQ_CONSTS_SVH
`define PIRQ_OFS_CTL0      32'h0000_2200
`define PIRQ_OFS_CTL1      32'h0000_2201
`define PIRQ_OFS_CTL2      32'h0000_2202
`define PIRQ_OFS_CTL3      32'h0000_2203
`define PIRQ_OFS_BOOT      32'h0000_2204
`define PIRQ_OFS_STAT      32'h0000_2205
`define PIRQ_RST_CTL0      32'h0A41_8820
`define PIRQ_RST_CTL1      32'h16A4_A0E6
`define PIRQ_RST_CTL2      32'h2307_B9AC
`define PIRQ_RST_CTL3      32'h0000_0012
`define PIRQ_RST_BOOT      32'h0000_0000
`define PIRQ_FLD_W         5
`define PIRQ_FLD_PER_REG   6
`define PIRQ_NUM_SLOTS     19
`define PIRQ_NUM_SRC       25
`define PIRQ_SEL_HIGH      5'h1F
`define PIRQ_VEC_BASE      8'h2C
`define PIRQ_VEC_STEP      8'h04
`define PIRQ_BOOT_SLOT_A   1
`define PIRQ_BOOT_SLOT_B   9
`define PIRQ_PERIPH_SLOT_SRC 5'h0E
`define PIRQ_LAT_NS        400
`define PIRQ_CLK_NS        40
`define PIRQ_LAT_CYC       (`PIRQ_LAT_NS / `PIRQ_CLK_NS)
`endif

// File: rtl/pirq_pkg.sv
// types for the peripheral interrupt router
package pirq_pkg;
  typedef enum logic [1:0] {
    PIRQ_BUS_IDLE = 2'b00,
    PIRQ_BUS_ACK  = 2'b01
  } pirq_bus_t;
  typedef enum logic [1:0] {
    PIRQ_ACK_RTI  = 2'b00,
    PIRQ_ACK_RDCLR = 2'b01,
    PIRQ_ACK_W1C  = 2'b10
  } pirq_ack_t;
endpackage

// File: rtl/pirq_router.sv
// peripheral interrupt router: source selection, slot priority, registers
//
// Design decisions made here: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "pirq_consts.svh"
module pirq_router #(
  parameter int NUM_SLOTS = `PIRQ_NUM_SLOTS,
  parameter int NUM_SRC   = `PIRQ_NUM_SRC
) (
  // clock, reset and enable
  input  wire logic                 clk_sys,
  input  wire logic                 nrst,
  input  wire logic                 clk_en,
  // avalon-mm slave
  input  wire logic [31:0]          avs_address,
  input  wire logic                 avs_read,
  input  wire logic                 avs_write,
  input  wire logic [3:0]           avs_byteenable,
  input  wire logic [31:0]          avs_writedata,
  output logic [31:0]               avs_readdata,
  output logic                      avs_waitrequest,
  output logic [1:0]                avs_response,
  // peripheral request lines, one per source code
  input  wire logic [NUM_SRC-1:0]   src_req,
  // strap: unmask boot slots 1 and 9 at reset
  input  wire logic                 boot_unmask_strap,
  // towards the core sequencer
  output logic [NUM_SLOTS-1:0]      slot_req,
  output logic                      core_irq,
  output logic [7:0]                core_vector,
  output logic [NUM_SLOTS-1:0]      boot_unmask
);

  // ************************************************************
  // functions
  // ************************************************************

  // select codes below the source count pick a request line, the
  // top code ties the slot high for software triggers, and every
  // other code, the reserved one included, leaves the slot idle
  // source for one select code; undefined codes give low
  function automatic logic pick_src(input logic [4:0] sel,
                                    input logic [NUM_SRC-1:0] req);
    logic v;
    v = 1'b0;
    if (sel == `PIRQ_SEL_HIGH)
      v = 1'b1;
    else if (32'(sel) < NUM_SRC)
      v = req[sel];
    return v;
  endfunction

  // vector address of a slot
  function automatic logic [7:0] slot_vec(input logic [4:0] n);
    return `PIRQ_VEC_BASE + {n, 2'b00};
  endfunction

  // ************************************************************
  // registers
  // ************************************************************

  logic [31:0]      ctl_r [0:3];
  logic [31:0]      ctl_nxt [0:3];
  logic [31:0]      boot_r;
  logic             strap_seen_r;
  logic [NUM_SLOTS-1:0] slot_r;
  logic             irq_r;
  logic [7:0]       vec_r;
  logic [NUM_SLOTS-1:0] unmask_r;
  logic [31:0]      rdata_r;
  logic [1:0]       resp_r;
  pirq_pkg::pirq_bus_t bus_r;

  // ************************************************************
  // bus decode
  // ************************************************************

  // word index map: four routing words, then the boot unmask word,
  // then a read-only view of the routed slot levels. anything else
  // answers with an error response, reads zero and ignores writes.
  // a request is taken only while the handshake is idle, so a held
  // request is never taken twice in a row.
  wire logic        req_any  = avs_read | avs_write;
  wire logic        take     = clk_en & req_any &
                               (bus_r == pirq_pkg::PIRQ_BUS_IDLE);
  wire logic [31:0] idx      = avs_address >> 2;
  wire logic        hit_ctl  = (idx >= `PIRQ_OFS_CTL0) &&
                               (idx <= `PIRQ_OFS_CTL3);
  wire logic        hit_boot = (idx == `PIRQ_OFS_BOOT);
  wire logic        hit_stat = (idx == `PIRQ_OFS_STAT);
  wire logic        mapped   = hit_ctl | hit_boot | hit_stat;
  wire logic [1:0]  ctl_sel  = idx[1:0];
  wire logic [31:0] be_mask  = {{8{avs_byteenable[3]}},
                                {8{avs_byteenable[2]}},
                                {8{avs_byteenable[1]}},
                                {8{avs_byteenable[0]}}};
  wire logic [31:0] wr_merge = (ctl_r[ctl_sel] & ~be_mask) |
                               (avs_writedata & be_mask);

  // next routing values: whole 32-bit word read, write merged per byte lane under byteenable
  always_comb
  begin
    for (int i = 0; i < 4; i++)
    begin
      ctl_nxt[i] = ctl_r[i];
    end
    if (take && avs_write && hit_ctl)
      ctl_nxt[ctl_sel] = wr_merge;
  end

  // read data mux
  wire logic [31:0] rd_val = hit_ctl  ? ctl_r[ctl_sel] :
                             hit_boot ? boot_r :
                             hit_stat ? 32'(slot_r) : 32'h0000_0000;

  // ************************************************************
  // routing and priority
  // ************************************************************

  logic [NUM_SLOTS-1:0] slot_nxt;
  logic [4:0]           top_slot;
  logic                 any_req;

  // each slot takes its field; six fields per register
  always_comb
  begin
    for (int s = 0; s < NUM_SLOTS; s++)
    begin
      slot_nxt[s] = pick_src(
        ctl_r[s / `PIRQ_FLD_PER_REG][(s % `PIRQ_FLD_PER_REG) *
          `PIRQ_FLD_W +: `PIRQ_FLD_W], src_req);
    end
  end

  // fixed priority: lowest slot number wins. the scan runs from the
  // lowest priority up so the last hit is the winner; software moves
  // a source up only by routing it into a lower-numbered slot
  always_comb
  begin
    top_slot = 5'h00;
    any_req  = 1'b0;
    for (int s = NUM_SLOTS - 1; s >= 0; s--)
    begin
      if (slot_nxt[s])
      begin
        top_slot = 5'(s);
        any_req  = 1'b1;
      end
    end
  end

  // boot unmask bits for slots 1 and 9
  wire logic [NUM_SLOTS-1:0] unmask_val =
    boot_r[0] ? ((NUM_SLOTS'(1) << `PIRQ_BOOT_SLOT_A) |
                 (NUM_SLOTS'(1) << `PIRQ_BOOT_SLOT_B))
              : '0;

  // ************************************************************
  // source acknowledge, latency and completion
  // ************************************************************

  // the router keeps no request latch of its own: each slot mirrors
  // the level its routed source drives, one clock later. clearing,
  // write latency and buffer completion all live in the sources, and
  // the core sees a cleared request leave after a single cycle.

  // write latency: a clearing write reaches the source some cycles
  // after the handler issues it; the slot keeps requesting until the
  // source level falls, so a return inside that gap sees the request
  // again. a read to the source block completes the write early, and
  // the slot then falls on the next edge. serial ports running dma
  // drop their level with the transfer, so no gap arises for them.
  wire logic [NUM_SLOTS-1:0] slot_level = slot_nxt;

  // acknowledge: read-to-clear and write-one-to-clear happen in the
  // source latches; sources acked by return only drop their level on
  // their own. the slot passes whichever level remains, unchanged.
  wire logic [NUM_SLOTS-1:0] slot_acked = slot_level;

  // completion: a dma source raises its level at count expiry, or in
  // completion mode once its buffer is empty; the router forwards the
  // level at whichever moment the source chose.
  wire logic [NUM_SLOTS-1:0] slot_final = slot_acked;

  // ************************************************************
  // bus handshake: answers one cycle after the request is taken
  // ************************************************************

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      bus_r   <= pirq_pkg::PIRQ_BUS_IDLE;
      rdata_r <= 32'h0000_0000;
      resp_r  <= 2'h0;
    end
    else if (clk_en)
    begin
      if (bus_r == pirq_pkg::PIRQ_BUS_ACK)
        bus_r <= pirq_pkg::PIRQ_BUS_IDLE;
      else if (take)
      begin
        bus_r   <= pirq_pkg::PIRQ_BUS_ACK;
        rdata_r <= avs_read ? rd_val : 32'h0000_0000;
        resp_r  <= mapped ? 2'h0 : 2'h2;
      end
    end
  end

  // waitrequest low only in the answer cycle. the request is taken
  // at one edge and answered at the next, so the master sees the
  // answer one cycle later; the ack state held through the answer cycle
  // keeps a still-held request from being taken at the edge ending it
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      avs_waitrequest <= 1'b1;
    else if (clk_en)
      avs_waitrequest <= !(take);
  end

  // routing registers, documented reset selects: slot n starts on
  // source n, so the secondary uart and two-wire codes stay unrouted
  // until software writes them into some field
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      ctl_r[0] <= `PIRQ_RST_CTL0;
      ctl_r[1] <= `PIRQ_RST_CTL1;
      ctl_r[2] <= `PIRQ_RST_CTL2;
      ctl_r[3] <= `PIRQ_RST_CTL3;
    end
    else if (clk_en)
    begin
      for (int i = 0; i < 4; i++)
      begin
        ctl_r[i] <= ctl_nxt[i];
      end
    end
  end

  // boot unmask option: strap caught once after release; software
  // may change it later through bit 0 of the boot word
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      boot_r       <= `PIRQ_RST_BOOT;
      strap_seen_r <= 1'b0;
    end
    else if (clk_en)
    begin
      if (!strap_seen_r)
      begin
        boot_r       <= {31'h0000_0000, boot_unmask_strap};
        strap_seen_r <= 1'b1;
      end
      else if (take && avs_write && hit_boot && avs_byteenable[0])
        boot_r <= {31'h0000_0000, avs_writedata[0]};
    end
  end

  // core side: registered requests, winner and its vector; the irq
  // and vector are taken from the same levels as the slot outputs,
  // so all three always agree within one cycle
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      slot_r   <= '0;
      irq_r    <= 1'b0;
      vec_r    <= 8'h00;
      unmask_r <= '0;
    end
    else if (clk_en)
    begin
      slot_r   <= slot_final;
      irq_r    <= any_req;
      vec_r    <= any_req ? slot_vec(top_slot) : 8'h00;
      unmask_r <= unmask_val;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************

  // every output is a plain copy of a register
  assign avs_readdata = rdata_r;
  assign avs_response = resp_r;
  assign slot_req     = slot_r;
  assign core_irq     = irq_r;
  assign core_vector  = vec_r;
  assign boot_unmask  = unmask_r;

endmodule
`default_nettype wire

// File: bench/pirq_router_monitor.sv
// checker for the interrupt router ports
`timescale 1ns/1ps
`default_nettype none
// *****
// port checks
// *****
module pirq_router_monitor #(
  parameter int NUM_SLOTS = 19
) (
  // clock and reset
  input wire logic                 clk_sys,
  input wire logic                 nrst,
  input wire logic                 clk_en,
  // register bus
  input wire logic [31:0]          avs_address,
  input wire logic                 avs_read,
  input wire logic                 avs_write,
  input wire logic [31:0]          avs_readdata,
  input wire logic                 avs_waitrequest,
  input wire logic [1:0]           avs_response,
  // core side
  input wire logic [NUM_SLOTS-1:0] slot_req,
  input wire logic                 core_irq,
  input wire logic [7:0]           core_vector,
  input wire logic [NUM_SLOTS-1:0] boot_unmask
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  // word index decode and vector of the lowest-numbered requesting slot
  wire logic [29:0] idx    = avs_address[31:2];
  wire logic        mapped = idx >= 30'h2200 && idx <= 30'h2205;
  logic [7:0]       exp_vec;
  always_comb
  begin
    exp_vec = 8'h00;
    for (int s = NUM_SLOTS - 1; s >= 0; s--)
      if (slot_req[s]) exp_vec = 8'h2C + 8'(4 * s);
  end
  property p_take; (avs_read || avs_write) && avs_waitrequest && clk_en
    |=> !avs_waitrequest; endproperty
  a_take: assert property (p_take) else $error("no answer");
  property p_pulse; $fell(avs_waitrequest) |=> avs_waitrequest; endproperty
  a_pulse: assert property (p_pulse) else $error("long answer");
  property p_idle; !avs_read && !avs_write && avs_waitrequest
    |=> avs_waitrequest; endproperty
  a_idle: assert property (p_idle) else $error("stray answer");
  property p_unmap; !avs_waitrequest && !mapped |-> avs_response == 2'h2
    && (avs_write || avs_readdata == 32'h0); endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped ok");
  property p_map; !avs_waitrequest && mapped |-> avs_response == 2'h0;
  endproperty
  a_map: assert property (p_map) else $error("mapped refused");
  property p_irq_on; (slot_req != '0) [*2] |-> core_irq; endproperty
  a_irq_on: assert property (p_irq_on) else $error("irq low");
  property p_irq_off; (slot_req == '0) [*2] |-> !core_irq
    && core_vector == 8'h00; endproperty
  a_irq_off: assert property (p_irq_off) else $error("irq high");
  property p_vec; $stable(slot_req) [*2] |-> core_vector == exp_vec;
  endproperty
  a_vec: assert property (p_vec) else $error("bad vector");
  property p_boot; (boot_unmask & ~19'h00202) == '0
    && boot_unmask[1] == boot_unmask[9]; endproperty
  a_boot: assert property (p_boot) else $error("bad unmask");
endmodule
bind pirq_router pirq_router_monitor #(.NUM_SLOTS(NUM_SLOTS)) mon_u (
  .clk_sys, .nrst, .clk_en, .avs_address, .avs_read, .avs_write,
  .avs_readdata, .avs_waitrequest, .avs_response, .slot_req, .core_irq,
  .core_vector, .boot_unmask);
`default_nettype wire

// File: bench/pirq_src_model.sv
// peripheral request sources with write-one-to-clear latches
`timescale 1ns/1ps
`default_nettype none
// *****
// source latches
// *****
module pirq_src_model (
  // clock and reset
  input wire logic        clk_sys,
  input wire logic        nrst,
  // latch set and clear
  input wire logic [24:0] set_req,
  input wire logic [24:0] clr_req,
  // request levels
  output logic     [24:0] src_req
);
  logic [24:0] src_r;
  assign src_req = src_r;
  // a one in clr drops only that bit, set wins
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      src_r <= 25'h0;
    else
      src_r <= (src_r & ~clr_req) | set_req;
  end
endmodule
`default_nettype wire

// File: bench/pirq_router_tb_top.sv
// self-checking bench for the interrupt router
`timescale 1ns/1ps
`default_nettype none
`include "pirq_consts.svh"
// *****
// bench
// *****
module pirq_router_tb_top;
  logic        clk_sys = 1'h0;
  logic        nrst = 1'h0;
  logic        clk_en = 1'h1;
  logic        strap = 1'h1;
  logic [31:0] avs_address = 32'h0;
  logic        avs_read = 1'h0;
  logic        avs_write = 1'h0;
  logic [3:0]  avs_byteenable = 4'hF;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [1:0]  avs_response;
  logic [24:0] set_req = 25'h0;
  logic [24:0] clr_req = 25'h0;
  logic [24:0] src_req;
  logic [18:0] slot_req;
  logic [18:0] boot_unmask;
  logic [7:0]  core_vector;
  logic        core_irq;
  logic [31:0] q;
  int          n_fail = 0;
  int          checks = 0;
  pirq_router dut_u (.clk_sys, .nrst, .clk_en, .avs_address,
    .avs_read, .avs_write, .avs_byteenable, .avs_writedata, .avs_readdata,
    .avs_waitrequest, .avs_response, .src_req, .boot_unmask_strap(strap),
    .slot_req, .core_irq, .core_vector, .boot_unmask);
  pirq_src_model src_u (.clk_sys, .nrst, .set_req, .clr_req, .src_req);
  // 25 MHz clock
  initial forever #20 clk_sys = ~clk_sys;
  task automatic end_of_test();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, exp);
    checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one access to word index a, held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [31:0] a, d);
    int n;
    n = 0;
    @(posedge clk_sys);
    avs_address <= a << 2;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (avs_waitrequest !== 1'h0 && n < 20);
    q = avs_readdata;
    avs_read <= 1'h0;
    avs_write <= 1'h0;
    if (avs_waitrequest !== 1'h0)
    begin
      n_fail++;
      end_of_test();
    end
  endtask
  // load the source latches with v, clearing the others
  task automatic src(input logic [24:0] v);
    @(posedge clk_sys);
    set_req <= v;
    clr_req <= ~v;
    @(posedge clk_sys);
    set_req <= 25'h0;
    clr_req <= 25'h0;
    repeat (4) @(posedge clk_sys);
  endtask
  // reset image: slot n takes source n
  function automatic logic [31:0] dflt(input int r);
    logic [31:0] w;
    w = 32'h0;
    for (int f = 0; f < 6; f++)
      w[f*5 +: 5] = (6 * r + f <= 18) ? 5'(6 * r + f) : 5'h00;
    return w;
  endfunction
  // slot s takes constant high, every other slot the unused code
  function automatic logic [31:0] walk(input int r, s);
    logic [31:0] w;
    w = 32'h0;
    for (int f = 0; f < 6; f++)
      w[f*5 +: 5] = (6 * r + f == s) ? 5'h1F : 5'h1E;
    return w;
  endfunction
  // main sequence
  initial
  begin
    repeat (2) @(posedge clk_sys);
    nrst <= 1'h1;
    for (int r = 0; r < 4; r++)
    begin
      bus(1'h0, `PIRQ_OFS_CTL0 + r, 32'h0);
      chk(q, dflt(r));
    end
    chk(32'(boot_unmask), 32'h202);
    bus(1'h0, `PIRQ_OFS_BOOT, 32'h0);
    chk(q, 32'h1);
    for (int n = 0; n < 19; n++)
    begin
      src(25'h1 << n);
      chk(32'(slot_req), 32'h1 << n);
      chk(32'(core_vector), 32'h2C + 4 * n);
    end
    bus(1'h0, `PIRQ_OFS_STAT, 32'h0);
    chk(q, 32'h40000);
    clk_en <= 1'h0;
    src(25'h1);
    chk(32'(slot_req), 32'h40000);
    clk_en <= 1'h1;
    src(25'h0040001);
    chk(32'(core_vector), 32'h2C);
    src(25'h1F80000);
    chk(32'(core_irq), 32'h0);
    chk(32'(slot_req), 32'h0);
    bus(1'h0, 32'h3000, 32'h0);
    chk(q, 32'h0);
    chk(32'(avs_response), 32'h2);
    src(25'h1FFFFFF);
    for (int c = 0; c < 32; c++)
    begin
      bus(1'h1, `PIRQ_OFS_CTL3, 32'(c));
      repeat (3) @(posedge clk_sys);
      chk(32'(slot_req[18]), 32'(c <= 24 || c == 31));
    end
    avs_byteenable <= 4'h2;
    bus(1'h1, `PIRQ_OFS_CTL1, 32'hFFFFFFFF);
    avs_byteenable <= 4'hF;
    bus(1'h0, `PIRQ_OFS_CTL1, 32'h0);
    chk(q, dflt(1) | 32'h0000FF00);
    src(25'h0);
    for (int s = 0; s < 19; s++)
    begin
      for (int r = 0; r < 4; r++)
        bus(1'h1, `PIRQ_OFS_CTL0 + r, walk(r, s));
      repeat (3) @(posedge clk_sys);
      chk(32'(slot_req), 32'h1 << s);
      chk(32'(core_vector), 32'h2C + 4 * s);
    end
    strap <= 1'h0;
    nrst <= 1'h0;
    repeat (2) @(posedge clk_sys);
    nrst <= 1'h1;
    bus(1'h0, `PIRQ_OFS_CTL3, 32'h0);
    chk(q, dflt(3));
    chk(32'(boot_unmask), 32'h0);
    bus(1'h1, `PIRQ_OFS_BOOT, 32'h1);
    repeat (3) @(posedge clk_sys);
    chk(32'(boot_unmask), 32'h202);
    end_of_test();
  end
endmodule
`default_nettype wire
